/* logic/fbw_key_gate.sv */
// key gate: watches flash key writes and grants one flash write per correct key pair
`timescale 1ns/1ps
module fbw_key_gate
	import fbw_pkg::*;
(
	input  wire logic clk,          // system clock
	input  wire logic resetn,       // async reset, active low
	input  wire logic ce,           // clock enable
	input  wire logic key_wr,       // one-cycle write to the key register
	input  wire logic [7:0] key_data, // key value written
	input  wire logic consume,      // a flash write used the grant
	output logic      unlocked,     // next flash write is permitted
	output logic      first_seen,   // first key accepted, second awaited
	output logic      lockout       // wrong key or key-sequence misuse seen, locked until reset
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		fbw_key_e st;
	} fbw_kg_state_s;

	fbw_kg_state_s r;
	fbw_kg_state_s next_r;

	always_comb begin
		next_r = r;
		case (r.st)
			FBW_KEY_IDLE: begin
				if (key_wr) begin
					next_r.st = (key_data == KEY_FIRST) ? FBW_KEY_FIRST_SEEN : FBW_KEY_LOCKED;
				end
			end
			FBW_KEY_FIRST_SEEN: begin
				if (key_wr) begin
					next_r.st = (key_data == KEY_SECOND) ? FBW_KEY_OPEN : FBW_KEY_LOCKED;
				end else if (consume) begin
					next_r.st = FBW_KEY_LOCKED;
				end
			end
			FBW_KEY_OPEN: begin
				// a further key write while open is treated as misuse
				if (key_wr) begin
					next_r.st = FBW_KEY_LOCKED;
				end else if (consume) begin
					next_r.st = FBW_KEY_IDLE;
				end
			end
			FBW_KEY_LOCKED: begin
				next_r.st = FBW_KEY_LOCKED;
			end
			default: begin
				next_r.st = FBW_KEY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r.st <= FBW_KEY_IDLE;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign unlocked   = (r.st == FBW_KEY_OPEN);
	assign first_seen = (r.st == FBW_KEY_FIRST_SEEN);
	assign lockout    = (r.st == FBW_KEY_LOCKED);

endmodule

/* logic/fbw_pkg.sv */
// package: register map, field layout, timing constants and carrier types of the flash block write sequencer
package fbw_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_CACHE_CONTROL = 12'h000;
	localparam logic [11:0] OFS_FLASH_KEY     = 12'h004;
	localparam logic [11:0] OFS_PS_CONTROL    = 12'h008;
	localparam logic [11:0] OFS_STATUS        = 12'h00C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_BLOCK_WRITE_SELECT = 0;
	localparam int BIT_PS_WRITE_ENABLE    = 0;
	localparam int BIT_PS_ERASE_ENABLE    = 1;
	localparam int BIT_ST_BUSY            = 0;
	localparam int BIT_ST_UNLOCKED        = 1;
	localparam int BIT_ST_KEY_STAGE       = 2;
	localparam int BIT_ST_LOCKOUT         = 3;

	// ----------------------------------------
	// reset values and key codes
	// ----------------------------------------
	localparam logic       RST_BLOCK_WRITE_SELECT = 1'b0;
	localparam logic [1:0] RST_PS_CONTROL         = 2'h0;
	localparam logic [7:0] KEY_FIRST              = 8'hA5;
	localparam logic [7:0] KEY_SECOND             = 8'hF1;
	localparam logic [7:0] ERASED_BYTE            = 8'hFF;
	localparam logic [1:0] BLOCK_LAST_LOW         = 2'h3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ         = 50;
	localparam int PROG_TIME_US    = 40;
	localparam int PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_TIME_US   = 20000;
	localparam int ERASE_CYCLES    = ERASE_TIME_US * CLK_MHZ;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		FBW_KEY_IDLE,
		FBW_KEY_FIRST_SEEN,
		FBW_KEY_OPEN,
		FBW_KEY_LOCKED
	} fbw_key_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  data;
	} fbw_xd_req_s;

	typedef struct packed {
		logic        wr;
		logic        erase;
		logic [15:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} fbw_prog_cmd_s;

endpackage

/* logic/fbw_prog_timer.sv */
// program timer: runs the busy period of one flash program or erase operation
`timescale 1ns/1ps
module fbw_prog_timer
	import fbw_pkg::*;
#(
	parameter int PROG_CNT  = PROG_CYCLES,  // cycles of one program operation
	parameter int ERASE_CNT = ERASE_CYCLES  // cycles of one page erase
) (
	input  wire logic clk,     // system clock
	input  wire logic resetn,  // async reset, active low
	input  wire logic ce,      // clock enable
	input  wire logic start,   // one-cycle start pulse
	input  wire logic erase,   // start is an erase
	output logic      busy,    // operation in progress
	output logic      done     // one-cycle pulse at the end
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] cnt;
	} fbw_tm_state_s;

	fbw_tm_state_s r;
	fbw_tm_state_s next_r;

	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		if (r.busy) begin
			if (r.cnt <= 32'h0000_0001) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.cnt  = 32'h0000_0000;
			end else begin
				next_r.cnt = r.cnt - 32'h0000_0001;
			end
		end else if (start) begin
			next_r.busy = 1'b1;
			next_r.cnt  = erase ? 32'(ERASE_CNT) : 32'(PROG_CNT);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign busy = r.busy;
	assign done = r.done;

endmodule

/* logic/fbw_sequencer.sv */
// flash block write sequencer: apb registers, key gate, write steering, block assembly and program timing
//
// Summary of operation
// - block write select bit enables block buffering
// - block mode programs only after final byte
// - block is four aligned bytes, 00b..11b
// - program starts right after 11b write
// - key pair 0xA5 then 0xF1 unlocks write
// - write enable steers data writes to flash
// - clearing write enable returns writes to ram
// - stored data read through code-space path
// - data-move reads always go to ram
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module fbw_sequencer
	import fbw_pkg::*;
#(
	parameter int PROG_CNT  = PROG_CYCLES,  // program operation length in cycles
	parameter int ERASE_CNT = ERASE_CYCLES  // erase operation length in cycles
) (
	input  wire logic          clk,           // system clock, 50 MHz
	input  wire logic          resetn,        // async reset, active low
	input  wire logic          ce,            // clock enable, freezes state when low
	// apb slave
	input  wire logic          psel,          // apb select
	input  wire logic          penable,       // apb access phase
	input  wire logic          pwrite,        // apb direction
	input  wire logic [11:0]   paddr,         // apb byte address
	input  wire logic [31:0]   pwdata,        // apb write data
	output logic               pready,        // apb ready
	output logic [31:0]        prdata,        // apb read data
	output logic               pslverr,       // apb error on unmapped address
	// cpu external-data move port
	input  fbw_xd_req_s        xd_req,        // data-move request
	output logic               xd_wait,       // stall the cpu
	output fbw_xd_req_s        ram_req,       // request passed to data ram
	// cpu code-space move port
	input  wire logic          code_rd,       // code-space read strobe
	input  wire logic [15:0]   code_addr,     // code-space read address
	output logic               flash_rd,      // read strobe to flash array
	output logic [15:0]        flash_rd_addr, // read address to flash array
	// flash array program port
	output fbw_prog_cmd_s      prog_cmd       // program or erase command
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic          blk_sel;
		logic [1:0]    program_store_control_reg;
		logic          pready;
		logic [31:0]   prdata;
		logic          pslverr;
		logic          xd_wait;
		fbw_xd_req_s   ram_req;
		logic          flash_rd;
		logic [15:0]   flash_rd_addr;
		fbw_prog_cmd_s prog_cmd;
		logic [31:0]   blk_data;
		logic [3:0]    blk_strb;
		logic [13:0]   blk_base;
		logic          seq_err;
	} fbw_state_s;

	fbw_state_s r;
	fbw_state_s next_r;

	logic apb_acc;
	logic key_wr;
	logic consume;
	logic unlocked;
	logic first_seen;
	logic lockout;
	logic tm_busy;
	logic tm_start;
	logic tm_erase;
	logic flash_wr;
	logic [1:0] low;

	function automatic logic [31:0] lane_place(input logic [7:0] b, input logic [1:0] lane);
		lane_place = {24'h00_0000, b} << {lane, 3'b000};
	endfunction

	function automatic logic [3:0] lane_bit(input logic [1:0] lane);
		lane_bit = 4'h1 << lane;
	endfunction

	assign apb_acc  = psel && penable && !r.pready;
	assign key_wr   = apb_acc && pwrite && (paddr == OFS_FLASH_KEY);
	assign low      = xd_req.addr[1:0];
	// while a flash operation runs the cpu is stalled, so no new write slips in
	assign flash_wr = xd_req.valid && xd_req.write && r.program_store_control_reg[BIT_PS_WRITE_ENABLE] && !tm_busy
		&& !r.prog_cmd.wr && !r.prog_cmd.erase;
	assign consume  = flash_wr;

	// ----------------------------------------
	// key gate and timer
	// ----------------------------------------
	fbw_key_gate u_key (
		.clk        (clk),
		.resetn     (resetn),
		.ce         (ce),
		.key_wr     (key_wr),
		.key_data   (pwdata[7:0]),
		.consume    (consume),
		.unlocked   (unlocked),
		.first_seen (first_seen),
		.lockout    (lockout)
	);

	fbw_prog_timer #(
		.PROG_CNT  (PROG_CNT),
		.ERASE_CNT (ERASE_CNT)
	) u_timer (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.start  (tm_start),
		.erase  (tm_erase),
		.busy   (tm_busy),
		.done   ()
	);

	assign tm_start = r.prog_cmd.wr || r.prog_cmd.erase;
	assign tm_erase = r.prog_cmd.erase;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r          = r;
		next_r.pready   = 1'b0;
		next_r.pslverr  = 1'b0;
		next_r.ram_req  = '0;
		next_r.prog_cmd = '0;
		next_r.flash_rd = 1'b0;

		// apb: one wait state, answer in the second access cycle
		if (apb_acc) begin
			next_r.pready = 1'b1;
			next_r.prdata = 32'h0000_0000;
			case (paddr)
				OFS_CACHE_CONTROL: begin
					if (pwrite) begin
						next_r.blk_sel = pwdata[BIT_BLOCK_WRITE_SELECT];
					end
					next_r.prdata[BIT_BLOCK_WRITE_SELECT] = r.blk_sel;
				end
				OFS_FLASH_KEY: begin
					next_r.prdata[1:0] = {lockout, unlocked};
				end
				OFS_PS_CONTROL: begin
					if (pwrite) begin
						next_r.program_store_control_reg = pwdata[1:0];
					end
					next_r.prdata[1:0] = r.program_store_control_reg;
				end
				OFS_STATUS: begin
					next_r.prdata[BIT_ST_BUSY]      = tm_busy || r.prog_cmd.wr || r.prog_cmd.erase;
					next_r.prdata[BIT_ST_UNLOCKED]  = unlocked;
					next_r.prdata[BIT_ST_KEY_STAGE] = first_seen;
					next_r.prdata[BIT_ST_LOCKOUT]   = lockout;
					next_r.prdata[4]                = r.seq_err;
					next_r.prdata[8 +: 4]           = r.blk_strb;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end

		// data-move steering
		next_r.xd_wait = tm_busy || tm_start || flash_wr;
		if (xd_req.valid && !(xd_req.write && r.program_store_control_reg[BIT_PS_WRITE_ENABLE])) begin
			next_r.ram_req = xd_req;
		end

		// clear comes first so that a hardware set in the same cycle wins
		if (apb_acc && pwrite && (paddr == OFS_STATUS) && pwdata[4]) begin
			next_r.seq_err = 1'b0;
		end

		if (flash_wr && unlocked) begin
			if (r.program_store_control_reg[BIT_PS_ERASE_ENABLE]) begin
				next_r.prog_cmd.erase = 1'b1;
				next_r.prog_cmd.addr  = xd_req.addr;
				next_r.blk_strb       = 4'h0;
			end else if (!r.blk_sel) begin
				// single-byte mode: program at once
				next_r.prog_cmd.wr   = 1'b1;
				next_r.prog_cmd.addr = xd_req.addr;
				next_r.prog_cmd.data = lane_place(xd_req.data, low);
				next_r.prog_cmd.strb = lane_bit(low);
			end else begin
				// block mode: bytes must arrive at lane 0,1,2,3 of one aligned word
				if ((low == 2'h0) || ((r.blk_strb == (lane_bit(low) - 4'h1))
					&& (r.blk_base == xd_req.addr[15:2]))) begin
					next_r.blk_base = xd_req.addr[15:2];
					next_r.blk_data = (low == 2'h0) ? lane_place(xd_req.data, low)
						: (r.blk_data | lane_place(xd_req.data, low));
					next_r.blk_strb = (low == 2'h0) ? 4'h1 : (r.blk_strb | lane_bit(low));
					if (low == BLOCK_LAST_LOW) begin
						next_r.prog_cmd.wr   = 1'b1;
						next_r.prog_cmd.addr = {xd_req.addr[15:2], 2'b00};
						next_r.prog_cmd.data = r.blk_data | lane_place(xd_req.data, low);
						next_r.prog_cmd.strb = 4'hF;
						next_r.blk_strb      = 4'h0;
					end
				end else begin
					// out of order: drop the partial block, nothing is programmed
					next_r.seq_err  = 1'b1;
					next_r.blk_strb = 4'h0;
				end
			end
		end else if (flash_wr) begin
			next_r.seq_err = 1'b1;
		end

		// code-space reads go straight to the flash read path
		next_r.flash_rd      = code_rd;
		next_r.flash_rd_addr = code_addr;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r         <= '0;
			r.blk_sel <= RST_BLOCK_WRITE_SELECT;
			r.program_store_control_reg   <= RST_PS_CONTROL;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign pready        = r.pready;
	assign prdata        = r.prdata;
	assign pslverr       = r.pslverr;
	assign xd_wait       = r.xd_wait;
	assign ram_req       = r.ram_req;
	assign flash_rd      = r.flash_rd;
	assign flash_rd_addr = r.flash_rd_addr;
	assign prog_cmd      = r.prog_cmd;

endmodule

/* testbench/fbw_cpu_model.sv */
// partner: cpu core issuing data moves and code-space reads
`timescale 1ns/1ps
module fbw_cpu_model
	import fbw_pkg::*;
(
	input  wire logic   clk,       // system clock
	input  wire logic   xd_wait,   // stall from sequencer
	output fbw_xd_req_s xd_req,    // data move
	output logic        code_rd,   // code read strobe
	output logic [15:0] code_addr  // code read address
);
	initial begin
		xd_req = '0;
		code_rd = 1'b0;
		code_addr = 16'h0000;
	end
	task automatic stall();
		int n;
		n = 0;
		while (xd_wait !== 1'b0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		// a stall that never ends is a failure of the run
		if (n >= 200)
			test_fbw_sequencer.num_errors++;
	endtask
	// one move; a block is fed in ascending low-address order by the caller
	task automatic move(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		stall();
		@(posedge clk);
		xd_req <= '{valid: 1'b1, write: wr, addr: a, data: d};
		@(posedge clk);
		// a released bus never shows the last value
		xd_req <= '{valid: 1'b0, write: 1'b0, addr: ~a, data: ~d};
		repeat (2) @(negedge clk);
		stall();
	endtask
	task automatic fetch(input logic [15:0] a);
		@(posedge clk);
		code_rd <= 1'b1;
		code_addr <= a;
		@(posedge clk);
		code_rd <= 1'b0;
		code_addr <= ~a;
	endtask
endmodule

/* testbench/fbw_sequencer_asserts.sv */
// checker: port-level assertions of the flash block write sequencer
`timescale 1ns/1ps
module fbw_sequencer_asserts
	import fbw_pkg::*;
#(
	parameter int PROG_CNT  = PROG_CYCLES,  // program length
	parameter int ERASE_CNT = ERASE_CYCLES  // erase length
) (
	input wire logic        clk,           // clock
	input wire logic        resetn,        // reset
	input wire logic        ce,            // enable
	input wire logic        psel,          // apb select
	input wire logic        penable,       // apb access
	input wire logic        pwrite,        // apb direction
	input wire logic [11:0] paddr,         // apb address
	input wire logic [31:0] pwdata,        // apb wdata
	input wire logic        pready,        // apb ready
	input wire logic [31:0] prdata,        // apb rdata
	input wire logic        pslverr,       // apb error
	input fbw_xd_req_s      xd_req,        // cpu move
	input wire logic        xd_wait,       // cpu stall
	input fbw_xd_req_s      ram_req,       // ram move
	input wire logic        code_rd,       // code read
	input wire logic [15:0] code_addr,     // code address
	input wire logic        flash_rd,      // flash read
	input wire logic [15:0] flash_rd_addr, // flash address
	input fbw_prog_cmd_s    prog_cmd       // program command
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_mv_wr;
		ce && xd_req.valid && xd_req.write;
	endsequence
	// the stall must last at least four cycles from the program command
	sequence s_hold;
		xd_wait [*4];
	endsequence
	a_code_read_path:
		assert property (ce && code_rd |=> flash_rd && flash_rd_addr == $past(code_addr))
		else $error("code read not passed on");
	a_move_read_ram:
		assert property (ce && xd_req.valid && !xd_req.write |=> ram_req.valid && !ram_req.write)
		else $error("data read left ram");
	a_ram_copy_exact:
		assert property (s_mv_wr |=> !ram_req.valid || (ram_req.write && ram_req.addr == $past(xd_req.addr)
			&& ram_req.data == $past(xd_req.data)))
		else $error("ram write altered");
	a_flash_not_ram:
		assert property ($rose(xd_wait) |-> !(ram_req.valid && ram_req.write))
		else $error("flash write also sent to ram");
	a_prog_after_write:
		assert property (prog_cmd.wr |-> $past(xd_req.valid && xd_req.write))
		else $error("program without a move write");
	a_block_last_byte:
		assert property (prog_cmd.wr && prog_cmd.strb == 4'hF |-> $past(xd_req.addr[1:0]) == BLOCK_LAST_LOW)
		else $error("block programmed before last byte");
	a_lane_shape:
		assert property (prog_cmd.wr |-> prog_cmd.strb == 4'hF || $onehot(prog_cmd.strb))
		else $error("bad byte lanes");
	a_busy_hold:
		assert property (prog_cmd.wr |-> s_hold ##[1:30] !xd_wait)
		else $error("stall too short or stuck");
	a_prog_one_shot:
		assert property (prog_cmd.wr |=> !prog_cmd.wr [*4])
		else $error("program command repeated");
endmodule

bind fbw_sequencer fbw_sequencer_asserts #(.PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)) chk (
	.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.xd_req(xd_req), .xd_wait(xd_wait), .ram_req(ram_req), .code_rd(code_rd), .code_addr(code_addr),
	.flash_rd(flash_rd), .flash_rd_addr(flash_rd_addr), .prog_cmd(prog_cmd));

/* testbench/test_fbw_sequencer.sv */
// testbench: firmware flash write sequences against the sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s exp %h got %h", nm, e, g); end end
module test_fbw_sequencer
	import fbw_pkg::*;
;
	logic          clk = 0;
	logic          resetn = 0;
	logic          ce = 1'b1;
	logic          psel = 0, penable = 0, pwrite = 0, pready, pslverr, xd_wait, code_rd, flash_rd;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0000_0000, prdata, rdat, s;
	logic [15:0]   code_addr, flash_rd_addr, fa, a;
	logic [7:0]    b[4];
	fbw_xd_req_s   xd_req, ram_req, rr;
	fbw_prog_cmd_s prog_cmd, pc;
	int            num_errors = 0, comparisons = 0, npc = 0, nrr = 0, ne = 0, n0, n1;
	always #10 clk = ~clk;
	fbw_sequencer #(.PROG_CNT(5), .ERASE_CNT(8)) uut (
		.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.xd_req(xd_req), .xd_wait(xd_wait), .ram_req(ram_req), .code_rd(code_rd), .code_addr(code_addr),
		.flash_rd(flash_rd), .flash_rd_addr(flash_rd_addr), .prog_cmd(prog_cmd));
	fbw_cpu_model cpu (.clk(clk), .xd_wait(xd_wait), .xd_req(xd_req), .code_rd(code_rd), .code_addr(code_addr));
	always @(posedge clk) begin
		if (prog_cmd.wr === 1'b1) begin
			pc = prog_cmd;
			npc++;
		end
		if (prog_cmd.erase === 1'b1)
			ne++;
		if (ram_req.valid === 1'b1) begin
			rr = ram_req;
			nrr++;
		end
		if (flash_rd === 1'b1)
			fa = flash_rd_addr;
	end
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		`CHK("pready", 1'b1, pready)
		`CHK("pslverr", ad > OFS_STATUS, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one keyed byte write; firmware keeps interrupts off around it
	task automatic fw_byte(input logic [15:0] ad, input logic [7:0] d);
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_FIRST});
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_SECOND});
		apb(1'b1, OFS_PS_CONTROL, 32'h0000_0001);
		cpu.move(1'b1, ad, d);
		apb(1'b1, OFS_PS_CONTROL, 32'h0000_0000);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#(20 * 40000);
		num_errors++;
		close_out();
	end
	initial begin
		s = $urandom(32'hee4f_8c2b);
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		// ----------------------------------------
		// reset values, read-back, unmapped place
		// ----------------------------------------
		for (int r = 0; r < 5; r++) begin
			apb(1'b0, 12'(r * 4), 32'h0000_0000);
			if (r < 4)
				`CHK("reset value", 32'h0000_0000, rdat)
		end
		apb(1'b1, OFS_CACHE_CONTROL, 32'h0000_0001);
		apb(1'b0, OFS_CACHE_CONTROL, 32'h0000_0000);
		`CHK("block select", 1'b1, rdat[BIT_BLOCK_WRITE_SELECT])
		apb(1'b1, OFS_CACHE_CONTROL, 32'h0000_0000);
		$display("test registers done");
		// ----------------------------------------
		// single-byte mode, every lane, ram and code paths
		// ----------------------------------------
		for (int i = 0; i < 4; i++) begin
			a = {16'($urandom()) & 16'hFFFC} | 16'(i);
			b[0] = 8'($urandom());
			n0 = npc;
			n1 = nrr;
			fw_byte(a, b[0]);
			`CHK("single prog", n0 + 1, npc)
			`CHK("no ram on flash write", n1, nrr)
			`CHK("lane", 4'h1 << i, pc.strb)
			`CHK("lane data", b[0], pc.data[8*i+:8])
			`CHK("erase", 1'b0, pc.erase)
			cpu.move(1'b1, a, ~b[0]);
			`CHK("ram write", {1'b1, 1'b1, a, ~b[0]}, rr)
			apb(1'b1, OFS_PS_CONTROL, 32'h0000_0001);
			cpu.move(1'b0, a + 16'h0001, 8'h00);
			`CHK("ram read", {1'b1, 1'b0, a + 16'h0001}, rr[25:8])
			apb(1'b1, OFS_PS_CONTROL, 32'h0000_0000);
			cpu.fetch(a);
			@(posedge clk);
			@(posedge clk);
			`CHK("code read", a, fa)
		end
		// clock enable low: a code read must leave no trace
		ce <= 1'b0;
		cpu.fetch(~a);
		@(posedge clk);
		ce <= 1'b1;
		`CHK("frozen by clock enable", a, fa)
		`CHK("no read while frozen", 1'b0, flash_rd)
		$display("test single done");
		// ----------------------------------------
		// block mode with a padded byte, then an out-of-order block
		// ----------------------------------------
		apb(1'b1, OFS_CACHE_CONTROL, 32'h0000_0001);
		a = 16'($urandom()) & 16'hFFFC;
		for (int i = 0; i < 4; i++)
			b[i] = (i == 2) ? ERASED_BYTE : 8'($urandom());
		n0 = npc;
		for (int i = 0; i < 4; i++) begin
			fw_byte(a | 16'(i), b[i]);
			`CHK("block prog count", n0 + (i == 3), npc)
		end
		`CHK("block strobe", 4'hF, pc.strb)
		`CHK("block data", {b[3], b[2], b[1], b[0]}, pc.data)
		`CHK("block addr", a[15:2], pc.addr[15:2])
		fw_byte(a, b[0]);
		fw_byte(a | 16'h0002, b[2]);
		`CHK("no prog out of order", n0 + 1, npc)
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("sequence error", 1'b1, rdat[4])
		apb(1'b1, OFS_STATUS, 32'h0000_0010);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("error cleared", 1'b0, rdat[4])
		apb(1'b1, OFS_CACHE_CONTROL, 32'h0000_0000);
		$display("test block done");
		// erase enable turns the next keyed write into a page erase
		n0 = ne;
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_FIRST});
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_SECOND});
		apb(1'b1, OFS_PS_CONTROL, 32'h0000_0003);
		cpu.move(1'b1, a, 8'h00);
		apb(1'b1, OFS_PS_CONTROL, 32'h0000_0000);
		`CHK("erase", n0 + 1, ne)
		// ----------------------------------------
		// one write per key pair, then a wrong key order
		// ----------------------------------------
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_FIRST});
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_SECOND});
		apb(1'b1, OFS_PS_CONTROL, 32'h0000_0001);
		n0 = npc;
		cpu.move(1'b1, a, b[1]);
		cpu.move(1'b1, a | 16'h0001, b[1]);
		apb(1'b1, OFS_PS_CONTROL, 32'h0000_0000);
		`CHK("one write per key", n0 + 1, npc)
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_SECOND});
		apb(1'b1, OFS_FLASH_KEY, {24'h00_0000, KEY_FIRST});
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("lockout", 1'b1, rdat[BIT_ST_LOCKOUT])
		fw_byte(a, b[1]);
		`CHK("locked write", n0 + 1, npc)
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("status after reset", 32'h0000_0000, rdat)
		$display("test key done");
		close_out();
	end
endmodule
